/* src/spcr_consts.svh */
// Constants for the serial port clock-rate, data and timing block.
// Assumes a single 50 MHz core clock and an APB register port.
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define SPCR_PADDR_W        12
`define SPCR_IDX_DIV        8'ha2
`define SPCR_IDX_DATA       8'ha3
`define SPCR_IDX_CTRL       8'ha4
`define SPCR_IDX_STAT       8'ha5
`define SPCR_BYTE_ADDR(i)   {2'h0, (i), 2'h0}

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define SPCR_DIV_RESET      8'h00
`define SPCR_DATA_RESET     8'h00
`define SPCR_CTRL_RESET     7'h10
`define SPCR_SEL_3WIRE      2'b00
`define SPCR_SEL_4WIRE      2'b01
`define SPCR_STAT_DONE      0
`define SPCR_STAT_WCOL      1
`define SPCR_STAT_MODF      2
`define SPCR_STAT_BUSY      3

// ----------------------------------------------------------------
// Transfer shape and timing
// ----------------------------------------------------------------
`define SPCR_LAST_EDGE      5'h0f
`define SPCR_END_TICK       5'h10
`define SPCR_BITS           4'h8
`define SPCR_CLK_NS         20
`define SPCR_TSLH_NS        140
`define SPCR_TSLH_CYC       (`SPCR_TSLH_NS / `SPCR_CLK_NS)
// Edge detect plus two register stages add three clocks to the tail
`define SPCR_TAIL_LAST      (`SPCR_TSLH_CYC - 3)

`endif

/* src/spcr_pkg.sv */
// Types shared by the serial port clock-rate, data and timing block.
// Assumes spcr_consts.svh supplies the numeric constants.
package spcr_pkg;

  // ----------------------------------------------------------------
  // States and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPCR_IDLE  = 2'b00,
    SPCR_MXFER = 2'b01,
    SPCR_SXFER = 2'b10
  } spcr_state_e;

  typedef struct packed {
    logic       int_en;
    logic [1:0] select_pin_mode;
    logic       clk_pol;
    logic       clock_phase_select;
    logic       master;
    logic       enable;
  } spcr_ctrl_s;

  typedef struct packed {
    logic o;
    logic oe;
  } spcr_pin_s;

endpackage : spcr_pkg

/* src/spcr_core.sv */
// Serial port: clock-rate divider, data buffers, master and slave timing.
// Assumes pin inputs are synchronous to ref_clk and an APB master.
//
// Summary of operation
// - Master clock is core_clock over 2(divider+1)
// - Data write loads transmit; master starts transfer
// - Data read returns receive buffer, never transmit
// - Slave MISO valid within four clocks of select
// - Slave MISO released within four clocks after select
// - Slave MISO updates within four clocks of shift
// - Phase one: MISO moves 6-8 clocks after end
// - Master samples late in bit; slave mid-bit
// - Done flag set each transfer, sticky, interrupt
// - Select pin mode: 3-wire, 4-wire input, driven
//
// Design decision made here: the APB slave port.
`include "spcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module spcr_core
  import spcr_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`SPCR_PADDR_W-1:0]  paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sck_in,
  input  wire logic                      mosi_in,
  input  wire logic                      miso_in,
  input  wire logic                      cs_in,
  output spcr_pin_s                      sck_drv,
  output spcr_pin_s                      mosi_drv,
  output spcr_pin_s                      miso_drv,
  output spcr_pin_s                      cs_drv,
  output logic                           irq_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spcr_state_e state_reg;
  spcr_ctrl_s  ctrl_reg;
  logic [7:0]  div_reg;
  logic [7:0]  txbuf_reg;
  logic [7:0]  rxbuf_reg;
  logic [7:0]  tx_sh_reg;
  logic [7:0]  rx_sh_reg;
  logic [7:0]  cnt_reg;
  logic [4:0]  tick_reg;
  logic [3:0]  tail_reg;
  logic        tail_run_reg;
  logic        sck_reg;
  logic        mosi_reg;
  logic        miso_reg;
  logic        sck_q_reg;
  logic        done_reg;
  logic        wcol_reg;
  logic        modf_reg;
  logic        pready_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr_fire;
  logic hit_div;
  logic hit_data;
  logic hit_ctrl;
  logic hit_stat;
  assign acc      = psel & penable;
  assign wr_fire  = acc & pready_reg & pwrite;
  assign hit_div  = (paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_DIV));
  assign hit_data = (paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_DATA));
  assign hit_ctrl = (paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_CTRL));
  assign hit_stat = (paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_STAT));

  // ----------------------------------------------------------------
  // Link decode
  // ----------------------------------------------------------------
  logic sel;
  logic slave_on;
  logic master_on;
  logic busy;
  logic tick;
  logic pha;
  logic sck_edge;
  logic lead;
  logic m_sample;
  logic m_shift;
  logic m_end;
  logic s_sample;
  logic s_shift;
  logic s_last;
  logic start_m;
  logic done_set;

  assign pha       = ctrl_reg.clock_phase_select;
  assign master_on = ctrl_reg.enable & ctrl_reg.master;
  assign slave_on  = ctrl_reg.enable & ~ctrl_reg.master;
  // Three-wire slave is always selected
  assign sel       = (ctrl_reg.select_pin_mode == `SPCR_SEL_3WIRE) | ~cs_in;
  assign busy      = (state_reg != SPCR_IDLE);
  assign tick      = (cnt_reg == div_reg);
  // Last cycle before the edge ending the bit gives slave most settling
  assign m_sample  = (state_reg == SPCR_MXFER) & tick &
                     ((~pha & tick_reg[0]) | (pha & ~tick_reg[0] & (tick_reg != 5'h00)));
  assign m_shift   = (state_reg == SPCR_MXFER) & tick &
                     ((~pha & tick_reg[0] & (tick_reg < `SPCR_LAST_EDGE)) |
                      (pha & ~tick_reg[0] & (tick_reg < `SPCR_END_TICK)));
  assign m_end     = (state_reg == SPCR_MXFER) & tick & (tick_reg == `SPCR_END_TICK);
  assign sck_edge  = sck_in ^ sck_q_reg;
  assign lead      = sck_edge & (sck_in != ctrl_reg.clk_pol);
  // External master keeps MOSI steady two clocks around the edge
  assign s_sample  = (state_reg == SPCR_SXFER) & sck_edge & (lead ^ pha);
  assign s_shift   = (state_reg == SPCR_SXFER) & sck_edge & ~(lead ^ pha);
  assign s_last    = s_sample & (tick_reg[3:0] == (`SPCR_BITS - 4'h1));
  assign start_m   = wr_fire & hit_data & master_on & ~busy;
  assign done_set  = m_end | s_last;

  // ----------------------------------------------------------------
  // APB answer: one wait cycle, then pready
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end else begin
      pready_reg <= acc & ~pready_reg;
      pslverr    <= acc & ~pready_reg & ~(hit_div | hit_data | hit_ctrl | hit_stat);
      if (acc & ~pready_reg & ~pwrite) begin
        if (hit_div) begin
          prdata <= {24'h00_0000, div_reg};
        end else if (hit_data) begin
          prdata <= {24'h00_0000, rxbuf_reg};
        end else if (hit_ctrl) begin
          prdata <= {25'h000_0000, ctrl_reg};
        end else if (hit_stat) begin
          prdata <= {28'h000_0000, busy, modf_reg, wcol_reg, done_reg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
  assign pready = pready_reg;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= `SPCR_DIV_RESET;
      ctrl_reg <= `SPCR_CTRL_RESET;
    end else begin
      if (wr_fire & hit_div) begin
        div_reg <= pwdata[7:0];
      end
      if (wr_fire & hit_ctrl) begin
        ctrl_reg <= pwdata[6:0];
      end else if (master_on & ~cs_in & (ctrl_reg.select_pin_mode == `SPCR_SEL_4WIRE)) begin
        ctrl_reg.master <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      wcol_reg <= 1'b0;
      modf_reg <= 1'b0;
      irq_req  <= 1'b0;
    end else begin
      if (done_set) begin
        done_reg <= 1'b1;
      end else if (wr_fire & hit_stat & pwdata[`SPCR_STAT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (wr_fire & hit_data & busy) begin
        wcol_reg <= 1'b1;
      end else if (wr_fire & hit_stat & pwdata[`SPCR_STAT_WCOL]) begin
        wcol_reg <= 1'b0;
      end
      if (master_on & ~cs_in & (ctrl_reg.select_pin_mode == `SPCR_SEL_4WIRE)) begin
        modf_reg <= 1'b1;
      end else if (wr_fire & hit_stat & pwdata[`SPCR_STAT_MODF]) begin
        modf_reg <= 1'b0;
      end
      irq_req <= (done_reg | done_set) & ctrl_reg.int_en;
    end
  end

  // ----------------------------------------------------------------
  // Transmit and receive buffers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_reg <= `SPCR_DATA_RESET;
      rxbuf_reg <= `SPCR_DATA_RESET;
    end else begin
      // A write during a transfer is a collision and is dropped
      if (wr_fire & hit_data & ~busy) begin
        txbuf_reg <= pwdata[7:0];
      end
      if (m_end) begin
        rxbuf_reg <= pha ? {rx_sh_reg[6:0], miso_in} : rx_sh_reg;
      end else if (s_last) begin
        rxbuf_reg <= {rx_sh_reg[6:0], mosi_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and divider
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SPCR_IDLE;
      cnt_reg   <= 8'h00;
      tick_reg  <= 5'h00;
    end else begin
      case (state_reg)
        SPCR_IDLE: begin
          cnt_reg  <= 8'h00;
          tick_reg <= 5'h00;
          if (start_m) begin
            state_reg <= SPCR_MXFER;
          end else if (slave_on & sel) begin
            state_reg <= SPCR_SXFER;
          end
        end
        SPCR_MXFER: begin
          if (tick) begin
            cnt_reg  <= 8'h00;
            tick_reg <= tick_reg + 5'h01;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
          if (m_end | ~master_on) begin
            state_reg <= SPCR_IDLE;
          end
        end
        SPCR_SXFER: begin
          if (s_last) begin
            tick_reg <= 5'h00;
          end else if (s_sample) begin
            tick_reg <= tick_reg + 5'h01;
          end
          if (~slave_on | ~sel) begin
            state_reg <= SPCR_IDLE;
          end
        end
        default: begin
          state_reg <= SPCR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift registers, MSB first
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      mosi_reg  <= 1'b0;
      miso_reg  <= 1'b0;
    end else begin
      if (start_m) begin
        tx_sh_reg <= pha ? pwdata[7:0] : {pwdata[6:0], 1'b0};
        mosi_reg  <= pwdata[7];
      end else if (m_shift) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        mosi_reg  <= tx_sh_reg[7];
      end else if ((state_reg == SPCR_IDLE) & slave_on & sel) begin
        tx_sh_reg <= pha ? txbuf_reg : {txbuf_reg[6:0], 1'b0};
        miso_reg  <= txbuf_reg[7];
      end else if (s_last) begin
        tx_sh_reg <= pha ? txbuf_reg : {txbuf_reg[6:0], 1'b0};
      end else if (s_shift) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        miso_reg  <= tx_sh_reg[7];
      end else if (tail_run_reg & (tail_reg == 4'(`SPCR_TAIL_LAST))) begin
        miso_reg <= txbuf_reg[7];
      end
      if (m_sample) begin
        rx_sh_reg <= {rx_sh_reg[6:0], miso_in};
      end else if (s_sample) begin
        rx_sh_reg <= {rx_sh_reg[6:0], mosi_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase-one tail timer after the final slave edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tail_run_reg <= 1'b0;
      tail_reg     <= 4'h0;
    end else begin
      if (s_last & pha) begin
        tail_run_reg <= 1'b1;
        tail_reg     <= 4'h0;
      end else if (tail_run_reg & ((tail_reg == 4'(`SPCR_TAIL_LAST)) | sck_edge)) begin
        tail_run_reg <= 1'b0;
      end else if (tail_run_reg) begin
        tail_reg <= tail_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial clock and pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg   <= 1'b0;
      sck_q_reg <= 1'b0;
      sck_drv   <= 2'b00;
      mosi_drv  <= 2'b00;
      miso_drv  <= 2'b00;
      cs_drv    <= 2'b00;
    end else begin
      sck_q_reg <= sck_in;
      if (state_reg != SPCR_MXFER) begin
        sck_reg <= ctrl_reg.clk_pol;
      end else if (tick & (tick_reg < `SPCR_END_TICK)) begin
        sck_reg <= ~sck_reg;
      end
      sck_drv.o   <= (state_reg == SPCR_MXFER) ? sck_reg : ctrl_reg.clk_pol;
      sck_drv.oe  <= master_on;
      mosi_drv.o  <= mosi_reg;
      mosi_drv.oe <= master_on;
      // Release is one clock after select rises, well inside budget
      miso_drv.o  <= miso_reg;
      miso_drv.oe <= slave_on & sel & (state_reg == SPCR_SXFER);
      // Select timing at the edges is the external master's duty
      cs_drv.o    <= ctrl_reg.select_pin_mode[0];
      cs_drv.oe   <= ctrl_reg.enable & ctrl_reg.select_pin_mode[1];
    end
  end

endmodule : spcr_core

`default_nettype wire

/* tb/spcr_core_chk.sv */
// Port checker for the serial port block: APB answers, clock rate, pins.
// Assumes one ref_clk domain; it shadows divider and control writes itself.
`include "spcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spcr_core_chk
  import spcr_pkg::*;
(
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [`SPCR_PADDR_W-1:0] paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     cs_in,
  input wire spcr_pin_s                sck_drv,
  input wire spcr_pin_s                miso_drv,
  input wire spcr_pin_s                cs_drv,
  input wire logic                     irq_req
);
  localparam int START_MAX = 520;
  logic       wr_now;
  logic       tog;
  logic       mapped;
  logic       slave_cfg;
  logic       sck_reg;
  logic [7:0] div_reg;
  logic [6:0] ctrl_reg;
  logic [1:0] age_reg;
  logic [8:0] gap_reg;
  logic [3:0] tog_reg;
  assign wr_now    = psel & penable & pready & pwrite;
  assign tog       = (sck_drv.o ^ sck_reg) & sck_drv.oe;
  assign mapped    = paddr inside {`SPCR_BYTE_ADDR(`SPCR_IDX_DIV), `SPCR_BYTE_ADDR(`SPCR_IDX_DATA),
                                   `SPCR_BYTE_ADDR(`SPCR_IDX_CTRL), `SPCR_BYTE_ADDR(`SPCR_IDX_STAT)};
  assign slave_cfg = ctrl_reg[0] & ~ctrl_reg[1] & (ctrl_reg[5:4] == `SPCR_SEL_4WIRE);
  // ----
  // Shadows; age lets registered pins settle after a control write
  // ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= `SPCR_DIV_RESET;
      ctrl_reg <= `SPCR_CTRL_RESET;
      age_reg  <= 2'h0;
    end else begin
      age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
      if (wr_now && paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_DIV)) div_reg <= pwdata[7:0];
      if (wr_now && paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_CTRL)) begin
        ctrl_reg <= pwdata[6:0];
        age_reg  <= 2'h0;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg <= 1'b0;
      gap_reg <= 9'h1ff;
      tog_reg <= 4'h0;
    end else begin
      sck_reg <= sck_drv.o;
      gap_reg <= tog ? 9'h0 : ((gap_reg == 9'h1ff) ? gap_reg : gap_reg + 9'h1);
      tog_reg <= tog ? tog_reg + 4'h1 : tog_reg;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  a_apb_answer: assert property ($rose(penable) && psel |-> s_wait ##1 s_answer)
    else $error("pready not in second access cycle");
  a_unmapped_err: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_sck_half: assert property (tog |-> ((tog_reg == 4'h0) ? gap_reg >= div_reg : gap_reg == div_reg))
    else $error("sck half period wrong");
  a_xfer_start: assert property (wr_now && paddr == `SPCR_BYTE_ADDR(`SPCR_IDX_DATA) && ctrl_reg[1:0] == 2'b11 |-> ##[1:START_MAX] tog)
    else $error("data write did not start master clock");
  a_cs_drive: assert property (age_reg == 2'h3 |-> cs_drv.oe == (ctrl_reg[0] & ctrl_reg[5]) && (!cs_drv.oe || cs_drv.o == ctrl_reg[4]))
    else $error("select pin drive wrong");
  a_miso_valid: assert property ($fell(cs_in) && slave_cfg |-> ##[0:4] miso_drv.oe)
    else $error("miso not driven after select");
  a_miso_release: assert property ($rose(cs_in) |-> ##[0:4] !miso_drv.oe)
    else $error("miso not released after select");
  a_irq_sticky: assert property (irq_req && !wr_now && !$past(wr_now) |=> irq_req)
    else $error("interrupt request dropped without clear");
endmodule : spcr_core_chk
bind spcr_core spcr_core_chk u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .cs_in, .sck_drv, .miso_drv, .cs_drv, .irq_req);
`default_nettype wire

/* tb/spcr_peer.sv */
// Far side: mode-0 slave answering the block, and a master task of either phase.
// Assumes the bench resolves every pin from the block's enables alone.
`timescale 1ns/1ps
`default_nettype none
module spcr_peer (
  input  wire logic ref_clk,
  input  wire logic sck_pin,
  input  wire logic mosi_pin,
  input  wire logic miso_pin,
  input  wire logic cs_pin,
  output logic      sck_m,
  output logic      mosi_m,
  output logic      cs_m,
  output logic      miso_s
);
  logic [7:0] s_tx = 8'h3c;
  logic [7:0] s_rx = 8'h00;
  logic [7:0] sh   = 8'h00;
  logic [2:0] n    = 3'h0;
  int         tail_cyc = 0;
  initial sck_m  = 1'b0;
  initial mosi_m = 1'b1;
  initial cs_m   = 1'b1;
  always @(negedge cs_pin) begin
    sh <= s_tx;
    n  <= 3'h0;
  end
  always @(posedge sck_pin) if (!cs_pin) s_rx <= {s_rx[6:0], mosi_pin};
  // Shift at once on the falling edge, well ahead of the next sample
  always @(negedge sck_pin) begin
    if (!cs_pin) begin
      n  <= n + 3'h1;
      sh <= (n == 3'h7) ? s_tx : {sh[6:0], 1'b0};
    end
  end
  // Deselected line shows the inverse, never a stale copy
  assign miso_s = cs_pin ? ~sh[7] : sh[7];
  task automatic mxfer(input logic ph, input logic [7:0] tx, output logic [7:0] rx);
    @(posedge ref_clk);
    cs_m <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) mosi_m <= tx[i];
      repeat (6) @(posedge ref_clk);
      sck_m <= 1'b1;
      if (ph) mosi_m <= tx[i];
      else rx[i] = miso_pin;
      repeat (6) @(posedge ref_clk);
      sck_m <= 1'b0;
      if (ph) rx[i] = miso_pin;
    end
    // Select stays low until the phase-one MISO move is seen
    tail_cyc = 0;
    while (ph && miso_pin === rx[0] && tail_cyc < 12) begin
      @(posedge ref_clk);
      tail_cyc++;
    end
    repeat (3) @(posedge ref_clk);
    cs_m   <= 1'b1;
    mosi_m <= ~mosi_m;
  endtask : mxfer
endmodule : spcr_peer
`default_nettype wire

/* tb/spcr_core_tb.sv */
// Bench: APB register tests, master and slave transfers against the peer.
// Assumes spcr_peer and the bound checker; 50 MHz ref_clk.
`include "spcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module spcr_core_tb
  import spcr_pkg::*;
;
  localparam logic [11:0] A_DIV  = `SPCR_BYTE_ADDR(`SPCR_IDX_DIV);
  localparam logic [11:0] A_DATA = `SPCR_BYTE_ADDR(`SPCR_IDX_DATA);
  localparam logic [11:0] A_CTRL = `SPCR_BYTE_ADDR(`SPCR_IDX_CTRL);
  localparam logic [11:0] A_STAT = `SPCR_BYTE_ADDR(`SPCR_IDX_STAT);
  localparam logic [11:0] A_NONE = 12'h2a0;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq_req;
  logic        sck_in, mosi_in, miso_in, cs_in, sck_m, mosi_m, cs_m, miso_s;
  spcr_pin_s   sck_drv, mosi_drv, miso_drv, cs_drv;
  int          compares    = 0;
  int          miscompares = 0;
  assign sck_in  = sck_drv.oe  ? sck_drv.o  : sck_m;
  assign mosi_in = mosi_drv.oe ? mosi_drv.o : mosi_m;
  assign miso_in = miso_drv.oe ? miso_drv.o : miso_s;
  assign cs_in   = cs_drv.oe   ? cs_drv.o   : cs_m;
  always #10 ref_clk = ~ref_clk;
  spcr_core u_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sck_in, .mosi_in, .miso_in, .cs_in, .sck_drv, .mosi_drv, .miso_drv, .cs_drv, .irq_req);
  spcr_peer u_peer (.ref_clk, .sck_pin(sck_in), .mosi_pin(mosi_in), .miso_pin(miso_in), .cs_pin(cs_in),
    .sck_m, .mosi_m, .cs_m, .miso_s);
  // ----
  // Bus tasks
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r)
  endtask : rd
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // ----
  // Tests
  // ----
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  b;
    int          i;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(A_DIV, 32'h0, "div reset");
    rd(A_DATA, 32'h0, "data reset");
    rd(A_CTRL, 32'h10, "ctrl reset");
    wr(A_NONE, 32'hff);
    apb(1'b0, A_NONE, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    rd(A_DIV, 32'h0, "div after stray write");
    $display("test reset finished");
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, 32'h03 | (m << 4));
      repeat (2) @(posedge ref_clk);
      `CHK("cs enable", m[1], cs_drv.oe)
      `CHK("cs level", m == 3, cs_drv.o & cs_drv.oe)
    end
    $display("test select modes finished");
    for (int k = 0; k <= 2; k += 2) begin
      wr(A_DIV, k);
      wr(A_CTRL, 32'h63);
      wr(A_DATA, 32'ha5 ^ k);
      wr(A_DATA, 32'h77);
      i = 0;
      do begin
        apb(1'b0, A_STAT, 32'h0, r, e);
        i++;
      end while (r[`SPCR_STAT_DONE] !== 1'b1 && i < 200);
      rd(A_STAT, 32'h3, "status after transfer");
      `CHK("irq high", 1'b1, irq_req)
      rd(A_DATA, 32'h3c, "master rx");
      `CHK("slave saw", 8'ha5 ^ k[7:0], u_peer.s_rx)
      rd(A_DIV, k, "div readback");
      wr(A_STAT, 32'h7);
      rd(A_STAT, 32'h0, "status cleared");
      `CHK("irq low", 1'b0, irq_req)
      $display("test master finished");
    end
    wr(A_CTRL, 32'h51);
    wr(A_DATA, 32'h96);
    u_peer.mxfer(1'b0, 8'h5b, b);
    `CHK("miso byte", 8'h96, b)
    rd(A_DATA, 32'h5b, "slave rx");
    rd(A_STAT, 32'h1, "slave done");
    $display("test slave finished");
    wr(A_CTRL, 32'h55);
    wr(A_DATA, 32'hc2);
    u_peer.mxfer(1'b1, 8'ha6, b);
    `CHK("miso byte phase one", 8'hc2, b)
    `CHK("miso tail cycles", 1'b1, u_peer.tail_cyc inside {[7:9]})
    rd(A_DATA, 32'ha6, "slave rx phase one");
    $display("test slave phase one finished");
    final_report();
  end
  // Whole run is a few hundred cycles; this leaves ample slack
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end
endmodule : spcr_core_tb
`default_nettype wire
